// *** src/dbx_pkg.sv ***
// package for the debug breakpoint exception logic
package dbx_pkg;
  localparam int DBX_ADDR_W = 32;
  localparam logic [7:0] DBX_DEBUG_VEC = 8'h01;
  localparam logic [7:0] DBX_MGMT_VEC = 8'hFF;
  localparam int DBX_RF_BIT = 16;
  localparam logic DBX_RF_RST = 1'b0;
  localparam logic [2:0] DBX_DRT_RST = 3'h0;

  typedef enum logic [2:0] {
    DBX_IDLE = 3'b000,
    DBX_CHECK = 3'b001,
    DBX_EXEC = 3'b011,
    DBX_HALTED = 3'b010,
    DBX_MGMT = 3'b110
  } dbx_state_t;
endpackage

// *** src/dbx_data_trap.sv ***
// data breakpoint trap timing for repeated string transfers
module dbx_data_trap
  import dbx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // iteration stream
  input wire logic iterDone,
  input wire logic isStringIn,
  input wire logic watchHit,
  input wire logic lastIter,
  // trap request
  output logic trapReq
);
  logic pendIn_q;
  logic trap_q;

  // input hits are reported one iteration later, or right after on the last iteration; output hits right after
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      pendIn_q <= 1'b0;
      trap_q <= 1'b0;
    end
    else
    begin
      trap_q <= 1'b0;
      if (iterDone)
      begin
        if (watchHit && !isStringIn)
          trap_q <= 1'b1;
        else if (pendIn_q)
          trap_q <= 1'b1;
        pendIn_q <= watchHit && isStringIn && !lastIter;
        if (watchHit && isStringIn && lastIter)
          trap_q <= 1'b1;
      end
    end
  end

  assign trapReq = trap_q;

  // checker helper: an input hit waits for the next finished iteration, however far away
  logic inHitSeen_q;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      inHitSeen_q <= 1'b0;
    else if (iterDone)
      inHitSeen_q <= watchHit && isStringIn && !lastIter;
  end

  chk_out_trap_next: assert property (@(posedge sys_clk) disable iff (!nrst)
    iterDone && watchHit && !isStringIn |=> trapReq) else $error("output trap not after hit iteration");
  chk_in_trap_late: assert property (@(posedge sys_clk) disable iff (!nrst)
    inHitSeen_q && iterDone |=> trapReq)
    else $error("input trap not one iteration late");
  chk_in_no_early: assert property (@(posedge sys_clk) disable iff (!nrst)
    iterDone && watchHit && isStringIn && !lastIter && !pendIn_q |=> !trapReq)
    else $error("input trap taken too early");
  chk_in_last_iter: assert property (@(posedge sys_clk) disable iff (!nrst)
    iterDone && watchHit && isStringIn && lastIter |=> trapReq)
    else $error("input trap on last iteration missed");
  cov_in_trap: cover property (@(posedge sys_clk) disable iff (!nrst) pendIn_q && iterDone);
endmodule

// *** src/dbx_core.sv ***
// debug breakpoint exception sequencing for one core
// Contract
// - an instruction breakpoint on an I/O instruction faults before any of it executes.
// - an instruction breakpoint on a halt instruction faults before the halted state is entered.
// - after an I/O restart management return the breakpoint faults again before re-execution.
// - a management return to a halt instruction faults again before halt is re-entered.
// - repeated string output traps right after the iteration touching the watched address.
// - repeated string input traps one iteration later than the iteration touching it; a hit on the last iteration traps right after it.
// - a breakpoint on a meaningless prefix need not match; only the opcode byte is guaranteed.
// - with resume flag clear and breakpoint set, return re-executes and faults to vector 1 again.
// - a set resume flag in the returned flags suppresses the same instruction breakpoint once.
// - a breakpoint coinciding with another fault may repeat once after that fault is handled.
// - the core may set the resume flag in the stacked flags on fault entry; setting it twice is harmless.
// - instruction breakpoints are faults before execution, data breakpoints traps after access.
module dbx_core
  import dbx_pkg::*;
#(
  parameter int ADDR_W = DBX_ADDR_W
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // instruction issue
  input wire logic instValid,
  input wire logic [ADDR_W-1:0] instAddr,
  input wire logic onOpcode,
  input wire logic isIo,
  input wire logic isHalt,
  input wire logic instDone,
  input wire logic otherFault,
  // breakpoint match
  input wire logic [ADDR_W-1:0] codeBpAddr,
  input wire logic codeBpEn,
  // management interrupt
  input wire logic mgmtReq,
  input wire logic ioRestartEn,
  input wire logic resumeFromMgmt,
  input wire logic wakeEvent,
  // debug handler return
  input wire logic handlerReturn,
  input wire logic retResumeFlag,
  // string iteration stream
  input wire logic iterDone,
  input wire logic isStringIn,
  input wire logic watchHit,
  input wire logic lastIter,
  // exception outputs
  output logic faultReq,
  output logic trapReq,
  output logic [7:0] excVector,
  output logic stackResumeFlag,
  output logic execGo,
  output logic haltActive,
  output logic mgmtActive,
  output logic resumeFlag
);
  dbx_state_t state_q;
  dbx_state_t state_d;
  logic rf_q;
  logic fault_q;
  logic stackRf_q;
  logic [7:0] vec_q;
  logic coFault_q;
  logic bpHit;
  logic dataTrap;

  // match only at the opcode byte
  assign bpHit = codeBpEn && onOpcode && (instAddr == codeBpAddr);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DBX_IDLE:
        if (instValid)
          state_d = DBX_CHECK;
      DBX_CHECK:
        if (bpHit && !rf_q)
          state_d = DBX_IDLE;
        else if (isHalt)
          state_d = DBX_HALTED;
        else
          state_d = DBX_EXEC;
      DBX_EXEC:
        if (mgmtReq && isIo && ioRestartEn)
          state_d = DBX_MGMT;
        else if (otherFault || instDone)
          state_d = DBX_IDLE;
      DBX_HALTED:
        if (mgmtReq)
          state_d = DBX_MGMT;
        else if (wakeEvent)
          state_d = DBX_IDLE;
      DBX_MGMT:
        if (resumeFromMgmt)
          state_d = DBX_CHECK;
      default:
        state_d = DBX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      state_q <= DBX_IDLE;
    else
      state_q <= state_d;
  end

  // breakpoint fault is raised in the check slot, before execution starts
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      fault_q <= 1'b0;
      vec_q <= 8'h00;
    end
    else
    begin
      fault_q <= 1'b0;
      if (state_q == DBX_CHECK && bpHit && !rf_q)
      begin
        fault_q <= 1'b1;
        vec_q <= DBX_DEBUG_VEC;
      end
      else if (state_q == DBX_EXEC && mgmtReq && isIo && ioRestartEn)
        vec_q <= DBX_MGMT_VEC;
      else if (state_q == DBX_HALTED && mgmtReq)
        vec_q <= DBX_MGMT_VEC;
    end
  end

  // note that a breakpoint-bearing instruction hit a second fault
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      coFault_q <= 1'b0;
    else if (state_q == DBX_EXEC && otherFault && bpHit)
      coFault_q <= 1'b1;
    else if (state_q == DBX_CHECK)
      coFault_q <= 1'b0;
  end

  // stacked flags image: the core sets resume flag on entry to other fault handlers
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      stackRf_q <= DBX_RF_RST;
    else if (state_q == DBX_EXEC && otherFault)
      stackRf_q <= 1'b1;
    else if (state_q == DBX_CHECK && bpHit && !rf_q)
      stackRf_q <= rf_q;
  end

  // resume flag: loaded from returned flags, cleared when the instruction completes
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      rf_q <= DBX_RF_RST;
    else if (handlerReturn)
      rf_q <= retResumeFlag;
    else if (state_q == DBX_EXEC && instDone)
      rf_q <= 1'b0;
    else if (state_q == DBX_HALTED && wakeEvent)
      rf_q <= 1'b0;
  end

  dbx_data_trap u_trap (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .iterDone(iterDone),
    .isStringIn(isStringIn),
    .watchHit(watchHit),
    .lastIter(lastIter),
    .trapReq(dataTrap)
  );

  assign faultReq = fault_q;
  assign trapReq = dataTrap;
  assign excVector = vec_q;
  assign stackResumeFlag = stackRf_q;
  assign execGo = (state_q == DBX_EXEC);
  assign haltActive = (state_q == DBX_HALTED);
  assign mgmtActive = (state_q == DBX_MGMT);
  assign resumeFlag = rf_q;

  chk_fault_before_exec: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == DBX_CHECK && bpHit && !rf_q |=> faultReq && !execGo && !haltActive)
    else $error("breakpoint fault not raised before execution");
  chk_fault_before_halt: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == DBX_CHECK && bpHit && !rf_q && isHalt |=> !haltActive)
    else $error("halt entered despite breakpoint");
  chk_io_restart_recheck: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtActive && resumeFromMgmt |=> state_q == DBX_CHECK)
    else $error("management return skipped breakpoint check");
  chk_halt_mgmt_entry: assert property (@(posedge sys_clk) disable iff (!nrst)
    haltActive && mgmtReq |=> mgmtActive && excVector == DBX_MGMT_VEC)
    else $error("management entry from halt missed");
  chk_fault_vector_one: assert property (@(posedge sys_clk) disable iff (!nrst)
    faultReq |-> excVector == DBX_DEBUG_VEC)
    else $error("breakpoint fault not on vector 1");
  chk_rf_suppresses: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == DBX_CHECK && rf_q |=> !faultReq)
    else $error("fault taken with resume flag set");
  chk_rf_clear_done: assert property (@(posedge sys_clk) disable iff (!nrst)
    execGo && instDone && !handlerReturn |=> !resumeFlag)
    else $error("resume flag not cleared after completion");
  chk_stack_rf_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    execGo && otherFault |=> stackResumeFlag)
    else $error("stacked resume flag not set on fault entry");
  chk_prefix_ignored: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == DBX_CHECK && !onOpcode |=> !faultReq)
    else $error("fault raised on prefix byte");

  // checker helpers: a check slot that follows a management return, and what that return resumes
  logic mgmtRet_q;
  logic mgmtFromHalt_q;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      mgmtRet_q <= 1'b0;
    else
      mgmtRet_q <= (state_q == DBX_MGMT) && resumeFromMgmt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      mgmtFromHalt_q <= 1'b0;
    else if (state_q == DBX_HALTED && mgmtReq)
      mgmtFromHalt_q <= 1'b1;
    else if (state_q == DBX_EXEC && mgmtReq && isIo && ioRestartEn)
      mgmtFromHalt_q <= 1'b0;
  end

  chk_issue_to_check: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == DBX_IDLE && instValid |=> state_q == DBX_CHECK)
    else $error("offered instruction skipped the check slot");
  chk_fault_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    faultReq |-> !execGo && !haltActive && !mgmtActive)
    else $error("fault raised while instruction runs");
  chk_fault_single: assert property (@(posedge sys_clk) disable iff (!nrst)
    faultReq |=> !faultReq)
    else $error("fault held longer than one cycle");
  chk_exec_from_check: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(execGo) |-> $past(state_q == DBX_CHECK))
    else $error("execution started without a check slot");
  chk_halt_from_check: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(haltActive) |-> $past(state_q == DBX_CHECK && isHalt))
    else $error("halt entered without a check slot");
  chk_halt_held: assert property (@(posedge sys_clk) disable iff (!nrst)
    haltActive && !mgmtReq && !wakeEvent |=> haltActive)
    else $error("halted state left without cause");
  chk_mgmt_io_entry: assert property (@(posedge sys_clk) disable iff (!nrst)
    execGo && mgmtReq && isIo && ioRestartEn |=> mgmtActive && excVector == DBX_MGMT_VEC)
    else $error("management entry from restartable I/O missed");
  chk_no_restart_stay: assert property (@(posedge sys_clk) disable iff (!nrst)
    execGo && mgmtReq && !ioRestartEn && !otherFault && !instDone |=> execGo)
    else $error("management entry taken with restart disabled");
  chk_mgmt_held: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtActive && !resumeFromMgmt |=> mgmtActive)
    else $error("management mode left without return");
  chk_mgmt_no_fault: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtActive |-> !faultReq)
    else $error("fault raised in management mode");
  chk_io_return_fault: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtRet_q && !mgmtFromHalt_q && bpHit && !rf_q |=> faultReq && !execGo)
    else $error("breakpoint not taken again after I/O restart");
  chk_halt_return_fault: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtRet_q && mgmtFromHalt_q && bpHit && !rf_q |=> faultReq && !haltActive)
    else $error("breakpoint not taken again before halt");
  chk_halt_reenter: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtRet_q && mgmtFromHalt_q && isHalt && !(bpHit && !rf_q) |=> haltActive)
    else $error("halt not re-entered after management return");
  chk_prefix_runs: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == DBX_CHECK && !onOpcode && !isHalt |=> execGo)
    else $error("prefix byte blocked execution");
  chk_vec_moves: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed(excVector) |-> faultReq || mgmtActive)
    else $error("vector changed without an exception");
  chk_rf_load: assert property (@(posedge sys_clk) disable iff (!nrst)
    handlerReturn |=> resumeFlag == $past(retResumeFlag))
    else $error("resume flag not loaded from returned flags");
  chk_rf_held: assert property (@(posedge sys_clk) disable iff (!nrst)
    resumeFlag && !handlerReturn && !(execGo && instDone) && !(haltActive && wakeEvent) |=> resumeFlag)
    else $error("resume flag lost early");
  chk_wake_clears_rf: assert property (@(posedge sys_clk) disable iff (!nrst)
    haltActive && wakeEvent && !mgmtReq && !handlerReturn |=> !haltActive && !resumeFlag)
    else $error("wake from halt left resume flag set");
  chk_rf_over_fault: assert property (@(posedge sys_clk) disable iff (!nrst)
    execGo && otherFault && !instDone && resumeFlag && !handlerReturn |=> resumeFlag)
    else $error("resume flag dropped by a second fault");
  chk_cofault_mark: assert property (@(posedge sys_clk) disable iff (!nrst)
    execGo && otherFault && bpHit |=> coFault_q)
    else $error("coinciding fault not noted");
  chk_stack_rf_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
    stackResumeFlag && !(state_q == DBX_CHECK && bpHit && !rf_q) |=> stackResumeFlag)
    else $error("stacked resume flag dropped");
  chk_fault_stack_image: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == DBX_CHECK && bpHit && !rf_q |=> !stackResumeFlag)
    else $error("stacked image wrong on breakpoint fault");

  cov_io_fault: cover property (@(posedge sys_clk) disable iff (!nrst) faultReq && isIo);
  cov_halt_mgmt: cover property (@(posedge sys_clk) disable iff (!nrst) haltActive ##1 mgmtActive);
  cov_rf_resume: cover property (@(posedge sys_clk) disable iff (!nrst) resumeFlag && execGo);
  cov_co_fault: cover property (@(posedge sys_clk) disable iff (!nrst) coFault_q);
endmodule

// *** tb/debug_breakpoint_exception_logic_test.sv ***
// self-checking bench for the debug breakpoint exception sequencing
module debug_breakpoint_exception_logic_test
  import dbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic instValid = 1'h0, onOpcode = 1'h0, isIo = 1'h0, isHalt = 1'h0, codeBpEn = 1'h0;
  logic ioRestartEn = 1'h0, retResumeFlag = 1'h0;
  logic iterDone = 1'h0, isStringIn = 1'h0, watchHit = 1'h0, lastIter = 1'h0;
  logic [DBX_ADDR_W-1:0] instAddr = '0, codeBpAddr = '0;
  // pulse lines: 0 done, 1 other fault, 2 mgmt, 3 mgmt return, 4 handler return, 5 wake
  logic [5:0] pls = '0;
  wire logic instDone, otherFault, mgmtReq, resumeFromMgmt, handlerReturn, wakeEvent;
  logic faultReq, trapReq, execGo, haltActive, mgmtActive, resumeFlag, stackResumeFlag;
  logic [7:0] excVector;
  logic notes[$]; // 1 data trap, 0 instruction fault
  int bad_count = 0, checks_done = 0, cycles = 0, k = 0;
  logic expT;

  assign {wakeEvent, handlerReturn, resumeFromMgmt, mgmtReq, otherFault, instDone} = pls;

  dbx_core DUT (.sys_clk(sys_clk), .nrst(nrst), .instValid(instValid), .instAddr(instAddr),
    .onOpcode(onOpcode), .isIo(isIo), .isHalt(isHalt), .instDone(instDone), .otherFault(otherFault),
    .codeBpAddr(codeBpAddr), .codeBpEn(codeBpEn), .mgmtReq(mgmtReq), .ioRestartEn(ioRestartEn),
    .resumeFromMgmt(resumeFromMgmt), .wakeEvent(wakeEvent), .handlerReturn(handlerReturn),
    .retResumeFlag(retResumeFlag), .iterDone(iterDone), .isStringIn(isStringIn), .watchHit(watchHit),
    .lastIter(lastIter), .faultReq(faultReq), .trapReq(trapReq), .excVector(excVector),
    .stackResumeFlag(stackResumeFlag), .execGo(execGo), .haltActive(haltActive),
    .mgmtActive(mgmtActive), .resumeFlag(resumeFlag));

  always #5 sys_clk = ~sys_clk;

  task automatic err(input string m);
    bad_count++;
    $display("ERROR at %0t: %s", $time, m);
  endtask

  task automatic chkLevel(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) err(m);
  endtask

  task automatic chkEvent(input logic isTrap);
    checks_done++;
    if ({trapReq, faultReq} !== {isTrap, !isTrap} || (!isTrap && excVector !== DBX_DEBUG_VEC))
      err("wrong exception kind or vector");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic pulse(input int i);
    @(posedge sys_clk) pls[i] <= 1'h1;
    @(posedge sys_clk) pls <= '0;
    @(negedge sys_clk);
  endtask

  // offers one instruction and checks where it went two edges later
  task automatic issue(input logic hitA, input logic op, input logic io, input logic halt_instruction, input logic expF);
    if (expF) notes.push_back(1'h0);
    @(posedge sys_clk)
    begin
      instValid <= 1'h1;
      instAddr <= hitA ? codeBpAddr : ~codeBpAddr;
      onOpcode <= op;
      isIo <= io;
      isHalt <= halt_instruction;
    end
    @(posedge sys_clk) instValid <= 1'h0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chkLevel(execGo, !expF && !halt_instruction, "execution start");
    chkLevel(haltActive, !expF && halt_instruction, "halt entry");
  endtask

  // a fault or trap pulse takes the oldest note
  always @(negedge sys_clk)
  begin
    if (faultReq === 1'h1 || trapReq === 1'h1)
    begin
      if (notes.size() == 0)
        err("exception not expected");
      else
        chkEvent(notes.pop_front());
    end
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err("timeout");
      results();
    end
  end

  initial
  begin
    k = $urandom(70939);
    @(posedge sys_clk) codeBpAddr <= $urandom();
    repeat (5) @(posedge sys_clk);
    nrst <= 1'h1;
    codeBpEn <= 1'h1;
    ioRestartEn <= 1'h1;
    issue(1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
    pulse(4);
    issue(1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
    @(posedge sys_clk) retResumeFlag <= 1'h1;
    pulse(4);
    chkLevel(resumeFlag, 1'h1, "resume flag load");
    issue(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    pulse(0);
    chkLevel(resumeFlag, 1'h0, "resume flag clear");
    chkLevel(execGo, 1'h0, "completion");
    $display("test resume flag done");
    issue(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    pulse(0);
    issue(1'h1, 1'h1, 1'h0, 1'h1, 1'h1);
    $display("test prefix and halt done");
    for (int h = 0; h < 2; h++)
    begin
      @(posedge sys_clk) codeBpEn <= 1'h0;
      issue(1'h1, 1'h1, !h, h[0], 1'h0);
      @(posedge sys_clk) codeBpEn <= 1'h1;
      pulse(2);
      chkLevel(mgmtActive, 1'h1, "management entry");
      chkLevel(excVector === DBX_MGMT_VEC, 1'h1, "management vector");
      notes.push_back(1'h0);
      pulse(3);
      repeat (2) @(negedge sys_clk);
      chkLevel(execGo | haltActive, 1'h0, "re-execution before fault");
    end
    @(posedge sys_clk) ioRestartEn <= 1'h0;
    issue(1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    pulse(2);
    chkLevel(mgmtActive, 1'h0, "management without restart");
    pulse(0);
    chkLevel(execGo, 1'h0, "completion without restart");
    $display("test management return done");
    @(posedge sys_clk) codeBpEn <= 1'h0;
    issue(1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
    pulse(5);
    chkLevel(haltActive, 1'h0, "wake from halt");
    issue(1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
    pulse(1);
    chkLevel(stackResumeFlag, 1'h1, "stacked resume flag");
    @(posedge sys_clk) codeBpEn <= 1'h1;
    pulse(4);
    issue(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    pulse(1);
    chkLevel(resumeFlag, 1'h1, "resume flag kept over second fault");
    issue(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    pulse(0);
    chkLevel(resumeFlag, 1'h0, "resume flag clear after second fault");
    $display("test other fault done");
    for (int d = 0; d < 4; d++)
    begin
      k = $urandom_range(3);
      for (int i = 0; i < 4; i++)
      begin
        expT = d[0] ? (i == k + 1 || (i == k && k == 3)) : (i == k);
        if (expT) notes.push_back(1'h1);
        @(posedge sys_clk)
        begin
          iterDone <= 1'h1;
          isStringIn <= d[0];
          watchHit <= (i == k);
          lastIter <= (i == 3);
        end
        @(posedge sys_clk) iterDone <= 1'h0;
        @(negedge sys_clk);
        chkLevel(trapReq, expT, "data trap timing");
      end
    end
    $display("test data trap done");
    repeat (4) @(negedge sys_clk);
    if (notes.size() != 0) err("expected exception missing");
    results();
  end
endmodule
